//--- verif/sdbs_ctrl_model.sv
`timescale 1ns/10ps

module sdbs_ctrl_model
    import sdbs_pkg::*;
(
    input  wire logic  clk_sys,
    output sdbs_pins_t pins
);

    // ----------------------------------------
    // command queue filled by the bench
    // ----------------------------------------
    typedef struct packed {
        sdbs_cmd_t   cmd;
        logic        bank;
        logic [10:0] addr;
    } sdbs_req_t;

    sdbs_req_t  q [$];
    sdbs_req_t  req;
    sdbs_pins_t last;

    task automatic send(input sdbs_cmd_t cmd, input logic bank, input logic [10:0] addr);
        // held two clocks so the pin filter passes it exactly once
        q.push_back({cmd, bank, addr});
        q.push_back({cmd, bank, addr});
    endtask

    // ----------------------------------------
    // pin driver, one command per cycle
    // ----------------------------------------
    initial pins = 16'h8000;

    always @(posedge clk_sys) begin
        #1;
        last = pins;
        // nop when nothing queued keeps the bank timers free to run
        if (q.size() > 0) begin
            req = q.pop_front();
        end else begin
            req = {SDBS_CMD_NOP, 1'h0, 11'h0};
        end
        // pins change just after the edge, steady at the next one
        case (req.cmd)
            SDBS_CMD_DESL:  pins = {1'h1, ~last[14:0]};
            SDBS_CMD_NOP:   pins = {4'h7, req.bank, req.addr};
            SDBS_CMD_BST:   pins = {4'h6, req.bank, req.addr};
            SDBS_CMD_READ:  pins = {4'h5, req.bank, req.addr};
            SDBS_CMD_WRITE: pins = {4'h4, req.bank, req.addr};
            SDBS_CMD_ACT:   pins = {4'h3, req.bank, req.addr};
            SDBS_CMD_PRE:   pins = {4'h2, req.bank, req.addr};
            SDBS_CMD_REF:   pins = {4'h1, req.bank, req.addr};
            default:        pins = {4'h0, req.bank, req.addr};
        endcase
    end

endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
`include "sdbs_params.svh"

module tb_top
    import sdbs_pkg::*;
;

    logic                              clk_sys;
    logic                              sys_rst;
    sdbs_pins_t                        pins;
    logic [`SDBS_BEAT_W-1:0]           burst_len;
    sdbs_state_t                       bank_state [`SDBS_NUM_BANKS];
    logic [`SDBS_NUM_BANKS-1:0]        bank_illegal;
    sdbs_cmd_t                         last_cmd;
    logic                              last_bank;
    logic [`SDBS_ADDR_W-1:0]           row_addr;
    logic [`SDBS_COL_W-1:0]            col_addr;
    logic                              col_auto_pre;
    logic                              col_strobe;
    int                                errors;
    int                                comparisons;
    int                                cycles;

    sdbs_ctrl_model partner (.clk_sys(clk_sys), .pins(pins));

    sdbs_top DUT (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .pins         (pins),
        .burst_len    (burst_len),
        .bank_state   (bank_state),
        .bank_illegal (bank_illegal),
        .last_cmd     (last_cmd),
        .last_bank    (last_bank),
        .row_addr     (row_addr),
        .col_addr     (col_addr),
        .col_auto_pre (col_auto_pre),
        .col_strobe   (col_strobe)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task automatic chk_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_state(input int b, input sdbs_state_t exp);
        comparisons++;
        if (bank_state[b] !== exp) begin
            errors++;
            $display("ERROR bank_state[%0d] expected %s seen %h", b, exp.name(), bank_state[b]);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios; first queued command acts 6 steps later, each next 2 more
    // ----------------------------------------
    task automatic t_reset;
        chk_state(0, SDBS_ST_IDLE);
        chk_state(1, SDBS_ST_IDLE);
        chk_vec("bank_illegal", 16'h0, {14'h0, bank_illegal});
        chk_vec("last_cmd", {12'h0, SDBS_CMD_DESL}, {12'h0, last_cmd});
        chk_vec("col_strobe", 16'h0, {15'h0, col_strobe});
        chk_vec("row_addr", 16'h0, {5'h0, row_addr});
    endtask

    task automatic t_activate;
        partner.send(SDBS_CMD_ACT, 1'h0, 11'h555);
        partner.send(SDBS_CMD_BST, 1'h0, 11'h0);
        step(6);
        chk_state(0, SDBS_ST_ACTIVATING);
        chk_vec("row_addr", 16'h0555, {5'h0, row_addr});
        step(2);
        chk_state(0, SDBS_ST_ROW_ACTIVE);
        chk_vec("bank_illegal", 16'h0, {14'h0, bank_illegal});
        // other bank opens while bank 0 is row-active; column too early
        partner.send(SDBS_CMD_ACT, 1'h1, 11'h2aa);
        partner.send(SDBS_CMD_READ, 1'h1, 11'h0);
        step(8);
        chk_vec("bank_illegal", 16'h2, {14'h0, bank_illegal});
        chk_vec("last_cmd", {12'h0, SDBS_CMD_READ}, {12'h0, last_cmd});
        chk_vec("last_bank", 16'h1, {15'h0, last_bank});
        chk_state(1, SDBS_ST_ROW_ACTIVE);
        chk_state(0, SDBS_ST_ROW_ACTIVE);
    endtask

    task automatic t_write_ap;
        // auto-precharge set, don't-care bits 9:8 set
        partner.send(SDBS_CMD_WRITE, 1'h0, 11'h7a5);
        partner.send(SDBS_CMD_PRE, 1'h0, 11'h0);
        step(6);
        chk_state(0, SDBS_ST_WRITE_AP);
        chk_vec("col_strobe", 16'h1, {15'h0, col_strobe});
        chk_vec("col_addr", 16'h00a5, {8'h0, col_addr});
        chk_vec("col_auto_pre", 16'h1, {15'h0, col_auto_pre});
        step(1);
        chk_state(0, SDBS_ST_WRITE_AP);
        step(1);
        chk_vec("bank_illegal", 16'h1, {14'h0, bank_illegal});
        chk_state(0, SDBS_ST_WR_RECOV_AP);
        step(2);
        chk_state(0, SDBS_ST_PRECHARGE);
        step(2);
        chk_state(0, SDBS_ST_IDLE);
    endtask

    task automatic t_precharge;
        partner.send(SDBS_CMD_PRE, 1'h1, 11'h0);
        partner.send(SDBS_CMD_PRE, 1'h0, 11'h400);
        step(6);
        chk_state(1, SDBS_ST_PRECHARGE);
        step(2);
        chk_state(1, SDBS_ST_IDLE);
        chk_state(0, SDBS_ST_IDLE);
        chk_vec("bank_illegal", 16'h0, {14'h0, bank_illegal});
    endtask

    task automatic t_write_recover;
        partner.send(SDBS_CMD_ACT, 1'h0, 11'h0);
        step(7);
        partner.send(SDBS_CMD_WRITE, 1'h0, 11'h03c);
        partner.send(SDBS_CMD_NOP, 1'h0, 11'h0);
        partner.send(SDBS_CMD_PRE, 1'h0, 11'h0);
        step(6);
        chk_state(0, SDBS_ST_WRITE);
        step(2);
        chk_state(0, SDBS_ST_WR_RECOV);
        step(2);
        chk_state(0, SDBS_ST_WR_RECOV);
        chk_vec("bank_illegal", 16'h1, {14'h0, bank_illegal});
        step(1);
        chk_state(0, SDBS_ST_ROW_ACTIVE);
        // read accepted in recovery
        partner.send(SDBS_CMD_WRITE, 1'h0, 11'h03c);
        partner.send(SDBS_CMD_DESL, 1'h0, 11'h0);
        partner.send(SDBS_CMD_READ, 1'h0, 11'h3c3);
        step(10);
        chk_state(0, SDBS_ST_READ);
        chk_vec("col_strobe", 16'h1, {15'h0, col_strobe});
        chk_vec("col_addr", 16'h00c3, {8'h0, col_addr});
        chk_vec("col_auto_pre", 16'h0, {15'h0, col_auto_pre});
    endtask

    // ----------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------
    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        clk_sys = 1'h0;
        sys_rst = 1'h1;
        burst_len = 9'h2;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (10) @(posedge clk_sys);
        #1;
        sys_rst = 1'h0;
        t_reset();
        t_activate();
        t_write_ap();
        t_precharge();
        t_write_recover();
        step(10);
        tally_and_finish();
    end

endmodule

//--- verilog/sdbs_bank.sv
`timescale 1ns/10ps
`include "sdbs_params.svh"

module sdbs_bank
    import sdbs_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    input  wire sdbs_cmd_t                 cmd,
    input  wire logic                      target,
    input  wire logic                      auto_pre,
    input  wire logic [`SDBS_BEAT_W-1:0]   burst_len,
    output sdbs_state_t                    state,
    output logic                           illegal
);

    localparam int RCD_CYC = `SDBS_RCD_CYC;
    localparam int RP_CYC  = `SDBS_RP_CYC;
    localparam logic [`SDBS_TIMER_W-1:0] RCD_LOAD = `SDBS_TIMER_W'(`SDBS_RCD_CYC - 1);
    localparam logic [`SDBS_TIMER_W-1:0] RP_LOAD  = `SDBS_TIMER_W'(`SDBS_RP_CYC - 1);
    localparam logic [`SDBS_TIMER_W-1:0] DPL_LOAD = `SDBS_TIMER_W'(`SDBS_DPL_CYC - 1);

    logic [`SDBS_TIMER_W-1:0] timer;
    logic [`SDBS_BEAT_W-1:0]  beats;
    sdbs_state_t              next_state;
    logic [`SDBS_TIMER_W-1:0] next_timer;
    logic [`SDBS_BEAT_W-1:0]  next_beats;
    logic                     next_illegal;
    logic                     col_hit;

    // any command other than deselect, nop or burst stop touching this bank
    function automatic logic sdbs_foreign(input sdbs_cmd_t c, input logic t);
        sdbs_foreign = (c == SDBS_CMD_REF) || (c == SDBS_CMD_MRS) ||
                       (t && (c == SDBS_CMD_READ || c == SDBS_CMD_WRITE ||
                              c == SDBS_CMD_ACT  || c == SDBS_CMD_PRE));
    endfunction

    function automatic sdbs_state_t sdbs_col_state(input sdbs_cmd_t c, input logic ap);
        if (c == SDBS_CMD_READ) begin
            sdbs_col_state = ap ? SDBS_ST_READ_AP : SDBS_ST_READ;
        end else begin
            sdbs_col_state = ap ? SDBS_ST_WRITE_AP : SDBS_ST_WRITE;
        end
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_state   = state;
        next_timer   = (timer != '0) ? timer - 1'b1 : timer;
        next_beats   = (beats != '0) ? beats - 1'b1 : beats;
        next_illegal = 1'b0;
        col_hit      = target && (cmd == SDBS_CMD_READ || cmd == SDBS_CMD_WRITE);
        case (state)
            SDBS_ST_IDLE: begin
                if (target && cmd == SDBS_CMD_ACT) begin
                    next_state = SDBS_ST_ACTIVATING;
                    next_timer = RCD_LOAD;
                end else if (col_hit) begin
                    next_illegal = 1'b1;
                end
            end
            SDBS_ST_ACTIVATING: begin
                next_illegal = sdbs_foreign(cmd, target);
                if (timer == '0) begin
                    next_state = SDBS_ST_ROW_ACTIVE;
                end
            end
            SDBS_ST_ROW_ACTIVE, SDBS_ST_READ, SDBS_ST_WRITE, SDBS_ST_WR_RECOV: begin
                if (col_hit) begin
                    next_state = sdbs_col_state(cmd, auto_pre);
                    next_beats = `SDBS_BEAT_W'(burst_len - 1'b1);
                end else if (target && cmd == SDBS_CMD_PRE && state != SDBS_ST_WR_RECOV) begin
                    next_state = SDBS_ST_PRECHARGE;
                    next_timer = RP_LOAD;
                end else if (sdbs_foreign(cmd, target)) begin
                    next_illegal = 1'b1;
                end else if (state == SDBS_ST_WR_RECOV) begin
                    if (timer == '0) begin
                        next_state = SDBS_ST_ROW_ACTIVE;
                    end
                end else if (state != SDBS_ST_ROW_ACTIVE) begin
                    if (cmd == SDBS_CMD_BST) begin
                        next_state = SDBS_ST_ROW_ACTIVE;
                    end else if (beats == '0 && state == SDBS_ST_READ) begin
                        next_state = SDBS_ST_ROW_ACTIVE;
                    end else if (beats == '0) begin
                        next_state = SDBS_ST_WR_RECOV;
                        next_timer = DPL_LOAD;
                    end
                end
            end
            SDBS_ST_READ_AP, SDBS_ST_WRITE_AP: begin
                next_illegal = sdbs_foreign(cmd, target) || cmd == SDBS_CMD_BST;
                if (beats == '0 && state == SDBS_ST_READ_AP) begin
                    next_state = SDBS_ST_PRECHARGE;
                    next_timer = RP_LOAD;
                end else if (beats == '0) begin
                    next_state = SDBS_ST_WR_RECOV_AP;
                    next_timer = DPL_LOAD;
                end
            end
            SDBS_ST_WR_RECOV_AP: begin
                // burst stop is a no-op once the burst is over
                next_illegal = sdbs_foreign(cmd, target);
                if (timer == '0) begin
                    next_state = SDBS_ST_PRECHARGE;
                    next_timer = RP_LOAD;
                end
            end
            SDBS_ST_PRECHARGE: begin
                // repeated precharge neither restarts nor shortens the period
                next_illegal = sdbs_foreign(cmd, target) && cmd != SDBS_CMD_PRE;
                if (timer == '0) begin
                    next_state = SDBS_ST_IDLE;
                end
            end
            default: begin
                next_state = SDBS_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= SDBS_ST_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            beats <= '0;
        end else begin
            beats <= next_beats;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            illegal <= 1'b0;
        end else begin
            illegal <= next_illegal;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_wap_continue;
        @(posedge clk_sys) disable iff (sys_rst)
        state == SDBS_ST_WRITE_AP && beats != '0 |=> state == SDBS_ST_WRITE_AP;
    endproperty
    a_wap_continue: assert property (p_wap_continue) else $error("auto write left early");

    property p_wap_recover;
        @(posedge clk_sys) disable iff (sys_rst)
        state == SDBS_ST_WRITE_AP && beats == '0 |=> state == SDBS_ST_WR_RECOV_AP
            ##[1:4] state == SDBS_ST_PRECHARGE;
    endproperty
    a_wap_recover: assert property (p_wap_recover) else $error("no auto precharge");

    property p_pre_idle;
        @(posedge clk_sys) disable iff (sys_rst)
        $changed(state) && state == SDBS_ST_PRECHARGE |-> ##RP_CYC state == SDBS_ST_IDLE;
    endproperty
    a_pre_idle: assert property (p_pre_idle) else $error("precharge period wrong");

    property p_pre_repeat;
        @(posedge clk_sys) disable iff (sys_rst)
        state == SDBS_ST_PRECHARGE && target && cmd == SDBS_CMD_PRE
            |=> !illegal && (state == SDBS_ST_IDLE || timer == $past(timer) - 1'b1);
    endproperty
    a_pre_repeat: assert property (p_pre_repeat) else $error("repeat precharge acted");

    property p_act_wait;
        @(posedge clk_sys) disable iff (sys_rst)
        state == SDBS_ST_IDLE && target && cmd == SDBS_CMD_ACT
            |=> state == SDBS_ST_ACTIVATING ##RCD_CYC state == SDBS_ST_ROW_ACTIVE;
    endproperty
    a_act_wait: assert property (p_act_wait) else $error("row delay wrong");

    property p_act_col_illegal;
        @(posedge clk_sys) disable iff (sys_rst)
        state == SDBS_ST_ACTIVATING && col_hit |=> illegal && state != SDBS_ST_READ
            && state != SDBS_ST_WRITE;
    endproperty
    a_act_col_illegal: assert property (p_act_col_illegal) else $error("early column taken");

    property p_wr_recov_back;
        @(posedge clk_sys) disable iff (sys_rst)
        state == SDBS_ST_WR_RECOV && !sdbs_foreign(cmd, target) && timer == '0
            |=> state == SDBS_ST_ROW_ACTIVE;
    endproperty
    a_wr_recov_back: assert property (p_wr_recov_back) else $error("recovery stuck");

    property p_wr_recov_pre;
        @(posedge clk_sys) disable iff (sys_rst)
        state == SDBS_ST_WR_RECOV && target && cmd == SDBS_CMD_PRE
            |=> illegal && state != SDBS_ST_PRECHARGE;
    endproperty
    a_wr_recov_pre: assert property (p_wr_recov_pre) else $error("precharge in recovery");

endmodule

//--- verilog/sdbs_params.svh
`ifndef SDBS_PARAMS_SVH
`define SDBS_PARAMS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define SDBS_CLK_NS        50

// ----------------------------------------
// bank timing, ns and derived cycles (rounded up)
// ----------------------------------------
`define SDBS_T_RCD_NS      60
`define SDBS_T_RP_NS       60
`define SDBS_T_DPL_NS      60
`define SDBS_RCD_CYC       ((`SDBS_T_RCD_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)
`define SDBS_RP_CYC        ((`SDBS_T_RP_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)
`define SDBS_DPL_CYC       ((`SDBS_T_DPL_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)

// ----------------------------------------
// widths, field positions, reset values
// ----------------------------------------
`define SDBS_NUM_BANKS     2
`define SDBS_ADDR_W        11
`define SDBS_COL_W         8
`define SDBS_AP_BIT        10
`define SDBS_BEAT_W        9
`define SDBS_TIMER_W       4
`define SDBS_PIN_W         16
`define SDBS_PIN_IDLE      16'h8000

`endif

//--- verilog/sdbs_pkg.sv
package sdbs_pkg;

    // ----------------------------------------
    // command pins, cs_n in the top bit
    // ----------------------------------------
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        bank_select_line;
        logic [10:0] addr;
    } sdbs_pins_t;

    typedef enum logic [3:0] {
        SDBS_CMD_DESL  = 4'b0000,
        SDBS_CMD_NOP   = 4'b0001,
        SDBS_CMD_BST   = 4'b0010,
        SDBS_CMD_READ  = 4'b0011,
        SDBS_CMD_WRITE = 4'b0100,
        SDBS_CMD_ACT   = 4'b0101,
        SDBS_CMD_PRE   = 4'b0110,
        SDBS_CMD_REF   = 4'b0111,
        SDBS_CMD_MRS   = 4'b1000
    } sdbs_cmd_t;

    typedef enum logic [3:0] {
        SDBS_ST_IDLE       = 4'b0000,
        SDBS_ST_ACTIVATING = 4'b0001,
        SDBS_ST_ROW_ACTIVE = 4'b0010,
        SDBS_ST_READ       = 4'b0011,
        SDBS_ST_READ_AP    = 4'b0100,
        SDBS_ST_WRITE      = 4'b0101,
        SDBS_ST_WRITE_AP   = 4'b0110,
        SDBS_ST_WR_RECOV   = 4'b0111,
        SDBS_ST_WR_RECOV_AP= 4'b1000,
        SDBS_ST_PRECHARGE  = 4'b1001
    } sdbs_state_t;

endpackage

//--- verilog/sdbs_top.sv
`timescale 1ns/10ps
`include "sdbs_params.svh"

module sdbs_top
    import sdbs_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire sdbs_pins_t               pins,
    input  wire logic [`SDBS_BEAT_W-1:0]  burst_len,
    output sdbs_state_t                   bank_state [`SDBS_NUM_BANKS],
    output logic [`SDBS_NUM_BANKS-1:0]    bank_illegal,
    output sdbs_cmd_t                     last_cmd,
    output logic                          last_bank,
    output logic [`SDBS_ADDR_W-1:0]       row_addr,
    output logic [`SDBS_COL_W-1:0]        col_addr,
    output logic                          col_auto_pre,
    output logic                          col_strobe
);

    sdbs_pins_t                          pin_s1;
    sdbs_pins_t                          pin_s2;
    sdbs_pins_t                          pin_s3;
    sdbs_pins_t                          pin_now;
    logic [`SDBS_PIN_W-1:0]              pin_agree;
    sdbs_cmd_t                           cmd;
    logic [`SDBS_NUM_BANKS-1:0]          target;
    logic                                auto_pre;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    function automatic sdbs_cmd_t sdbs_decode(input sdbs_pins_t p);
        if (p.cs_n) begin
            sdbs_decode = SDBS_CMD_DESL;
        end else begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h7:    sdbs_decode = SDBS_CMD_NOP;
                3'h6:    sdbs_decode = SDBS_CMD_BST;
                3'h5:    sdbs_decode = SDBS_CMD_READ;
                3'h4:    sdbs_decode = SDBS_CMD_WRITE;
                3'h3:    sdbs_decode = SDBS_CMD_ACT;
                3'h2:    sdbs_decode = SDBS_CMD_PRE;
                3'h1:    sdbs_decode = SDBS_CMD_REF;
                default: sdbs_decode = SDBS_CMD_MRS;
            endcase
        end
    endfunction

    function automatic logic sdbs_is_col(input sdbs_cmd_t c);
        sdbs_is_col = (c == SDBS_CMD_READ) || (c == SDBS_CMD_WRITE);
    endfunction

    // ----------------------------------------
    // pin synchroniser, three stages per bit
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_s1 <= `SDBS_PIN_IDLE;
            pin_s2 <= `SDBS_PIN_IDLE;
            pin_s3 <= `SDBS_PIN_IDLE;
        end else begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // the word moves only once stages two and three agree
    genvar gb;
    generate
        for (gb = 0; gb < `SDBS_PIN_W; gb++) begin : g_pin
            assign pin_agree[gb] = (pin_s2[gb] == pin_s3[gb]);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_now <= `SDBS_PIN_IDLE;
        end else if (&pin_agree) begin
            pin_now <= pin_s3;
        end else begin
            // word in transit reads as deselect, so a command counts once
            pin_now <= `SDBS_PIN_IDLE;
        end
    end

    assign cmd      = sdbs_decode(pin_now);
    assign auto_pre = pin_now.addr[`SDBS_AP_BIT];

    // ----------------------------------------
    // bank targeting
    // ----------------------------------------
    genvar gk;
    generate
        for (gk = 0; gk < `SDBS_NUM_BANKS; gk++) begin : g_bank
            // precharge with the auto bit set reaches every bank
            assign target[gk] = (pin_now.bank_select_line == 1'(gk)) ||
                                (cmd == SDBS_CMD_PRE && auto_pre);

            sdbs_bank u_bank (
                .clk_sys   (clk_sys),
                .sys_rst   (sys_rst),
                .cmd       (cmd),
                .target    (target[gk]),
                .auto_pre  (auto_pre),
                .burst_len (burst_len),
                .state     (bank_state[gk]),
                .illegal   (bank_illegal[gk])
            );

            property p_target_only;
                @(posedge clk_sys) disable iff (sys_rst)
                $rose(bank_illegal[gk]) && sdbs_is_col($past(cmd))
                    |-> $past(pin_now.bank_select_line) == 1'(gk);
            endproperty
            a_target_only: assert property (p_target_only) else $error("wrong bank flagged");

            property p_other_free;
                @(posedge clk_sys) disable iff (sys_rst)
                (bank_state[gk] == SDBS_ST_ROW_ACTIVE || bank_state[gk] == SDBS_ST_WR_RECOV) &&
                    cmd == SDBS_CMD_READ &&
                    pin_now.bank_select_line == 1'(gk)
                    |=> !bank_illegal[gk];
            endproperty
            a_other_free: assert property (p_other_free) else $error("legal read flagged");
        end
    endgenerate

    // ----------------------------------------
    // command record
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            last_cmd  <= SDBS_CMD_DESL;
            last_bank <= 1'b0;
        end else begin
            last_cmd  <= cmd;
            last_bank <= pin_now.bank_select_line;
        end
    end

    // ----------------------------------------
    // row and column address capture
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            row_addr <= '0;
        end else if (cmd == SDBS_CMD_ACT) begin
            row_addr <= pin_now.addr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            col_addr     <= '0;
            col_auto_pre <= 1'b0;
        end else if (sdbs_is_col(cmd)) begin
            // bits 8 and 9 dropped on column commands
            col_addr     <= pin_now.addr[`SDBS_COL_W-1:0];
            col_auto_pre <= auto_pre;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            col_strobe <= 1'b0;
        end else begin
            col_strobe <= sdbs_is_col(cmd);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_pin_settle;
        @(posedge clk_sys) disable iff (sys_rst)
        pin_s2 == pin_s3 |=> pin_now == $past(pin_s3);
    endproperty
    a_pin_settle: assert property (p_pin_settle) else $error("pin not sampled");

    property p_pin_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        pin_s2 != pin_s3 |=> pin_now.cs_n;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("unsettled pin taken");

    property p_col_mask;
        @(posedge clk_sys) disable iff (sys_rst)
        sdbs_is_col(cmd) |=> col_strobe && col_addr == $past(pin_now.addr[7:0]);
    endproperty
    a_col_mask: assert property (p_col_mask) else $error("column address wrong");

endmodule
